// ---- hdl/eecmd_core.sv ----
// Purpose: Serial command decoder for register and read instructions
// Assumes: Serial clock well below a quarter of CLK_I
// Notes: Array contents arrive on MEM_DATA_I for MEM_ADDR_O
// How it works
// RULE_01: Opcode 85h returns the volatile byte MSB first on falling edges.
// RULE_02: Volatile byte repeats while chip select stays low.
// RULE_03: Volatile read is served even while a write cycle runs.
// RULE_04: Host sends 81h, one data byte, then raises chip select.
// RULE_05: Volatile write changes only the buffer enable bit.
// RULE_06: Volatile write refused unless the write enable latch is set.
// RULE_07: Volatile write runs only if select rises at a byte boundary.
// RULE_08: Volatile register updates at once when select rises.
// RULE_09: Opcode 01h with one byte updates protect bits and latch.
// RULE_10: A second byte also updates drive strength and id lock.
// RULE_11: Status write accepted only with the write enable latch set.
// RULE_12: Status write dropped unless select rises after a whole byte.
// RULE_13: Status write with more than two data bytes is discarded.
// RULE_14: Status write refused while a nonvolatile cycle runs.
// RULE_15: Status and configuration bytes commit by separate strobes.
// RULE_16: Opcode 03h plus 24-bit address, data MSB first on falls.
// RULE_17: Address increments per byte, wraps to zero, until select rises.
// RULE_18: Opcode 0Bh adds eight dummy clocks before data.
// RULE_19: Dummy clocks ignore data input and keep outputs released.
// RULE_20: Opcode 3Bh sends two bits per falling edge after dummies.
// RULE_21: Opcode 06h sets the write enable latch.
// RULE_22: Unknown opcodes are ignored with outputs released to frame end.
`timescale 1ns/1ps
module eecmd_core (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CS_N_I,
  input wire logic SCK_I,
  input wire logic IO0_I,
  output logic IO0_O,
  output logic IO0_OE_O,
  output logic IO1_O,
  output logic IO1_OE_O,
  input wire logic WIP_I,
  input wire logic BUFFER_LOADED_FLAG_I,
  input wire logic [7:0] MEM_DATA_I,
  output logic [eecmd_pkg::ADDR_W-1:0] MEM_ADDR_O,
  output logic WEL_O,
  output logic BUFFER_ENABLE_BIT_O,
  output logic [7:0] STATUS_O,
  output logic [7:0] CONFIG_O,
  output logic STATUS_WR_O,
  output logic CONFIG_WR_O
);
  import eecmd_pkg::*;
  logic [SYNC_N-1:0] lvl;
  logic [SYNC_N-1:0] rise;
  logic [SYNC_N-1:0] fall;
  logic cs_lvl;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic din;

  eecmd_state_t state_r;
  eecmd_state_t state_nxt;

  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic [1:0] byte_cnt_r;
  logic [1:0] byte_cnt_nxt;
  logic [7:0] shin_r;
  logic [7:0] shin_nxt;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic fast_r;
  logic fast_nxt;
  logic dual_r;
  logic dual_nxt;
  logic wel_r;
  logic wel_nxt;
  logic buffer_enable_bit_r;
  logic buffer_enable_bit_nxt;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] config_r;
  logic [7:0] config_nxt;
  logic stwr_r;
  logic stwr_nxt;
  logic cfwr_r;
  logic cfwr_nxt;

  logic [7:0] bit_in;
  logic [7:0] vreg;
  logic run;
  logic taken;
  logic drive;
  logic [1:0] bits;
  logic boundary;

  // Opcode to first state after the opcode byte
  function automatic eecmd_state_t decode(input logic [7:0] op);
    if (op == OP_WR_ENABLE) begin
      decode = ST_WRITE_ENABLE_CMD_END;
    end else if (op == OP_VREG_RD) begin
      decode = ST_VR_READ;
    end else if (op == OP_VREG_WR) begin
      decode = ST_VR_WDATA;
    end else if (op == OP_STAT_WR) begin
      decode = ST_SR_DATA;
    end else if ((op == OP_READ) || (op == OP_FAST_RD) ||
                 (op == OP_DUAL_RD)) begin
      decode = ST_ADDR;
    end else begin
      decode = ST_IGNORE; // RULE_22
    end
  endfunction

  eecmd_sync u_sync (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .pin_i({IO0_I, SCK_I, CS_N_I}),
    .lvl_o(lvl),
    .rise_o(rise),
    .fall_o(fall)
  );
  // Serial edges count only while select is low
  assign cs_lvl = lvl[0];
  assign cs_rise = rise[0];
  assign cs_fall = fall[0];
  assign sck_rise = rise[1] & ~cs_lvl;
  assign sck_fall = fall[1] & ~cs_lvl;
  assign din = lvl[2];

  // Read-only bits read as zero; loaded flag comes from the buffer logic
  always_comb begin
    vreg = BYTE_ZERO;
    vreg[VR_BUFFER_ENABLE_BIT_BIT] = buffer_enable_bit_r;
    vreg[VR_BUFFER_LOADED_FLAG_BIT] = BUFFER_LOADED_FLAG_I;
  end

  // Volatile read ignores the write-in-progress input on purpose
  assign run = ~cs_lvl &&
               ((state_r == ST_RD_DATA) || (state_r == ST_VR_READ)); // RULE_03
  assign boundary = (bit_cnt_r == CNT_ZERO);
  assign bit_in = {shin_r[6:0], din};

  eecmd_tx u_tx (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .run_i(run),
    .dual_i(dual_r),
    .fall_i(sck_fall),
    .byte_i((state_r == ST_VR_READ) ? vreg : MEM_DATA_I), // RULE_02
    .taken_o(taken),
    .drive_o(drive),
    .bits_o(bits)
  );

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    shin_nxt = shin_r;
    hold_nxt = hold_r;
    addr_nxt = addr_r;
    fast_nxt = fast_r;
    dual_nxt = dual_r;
    wel_nxt = wel_r;
    buffer_enable_bit_nxt = buffer_enable_bit_r;
    status_nxt = status_r;
    config_nxt = config_r;
    stwr_nxt = 1'b0;
    cfwr_nxt = 1'b0;
    // Writes commit on the select rise, where alignment is known
    if (cs_rise) begin
      state_nxt = ST_IDLE;
      if ((state_r == ST_WRITE_ENABLE_CMD_END) && boundary) begin
        wel_nxt = 1'b1; // RULE_21
      end
      if ((state_r == ST_VR_WDATA) && boundary && wel_r &&
          (byte_cnt_r == BYTES_ONE)) begin // RULE_04
        buffer_enable_bit_nxt = shin_r[VR_BUFFER_ENABLE_BIT_BIT]; // RULE_05 RULE_06 RULE_07 RULE_08
      end
      if ((state_r == ST_SR_DATA) && boundary && wel_r && !WIP_I &&
          ((byte_cnt_r == BYTES_ONE) || (byte_cnt_r == BYTES_TWO))) begin
        // RULE_11 RULE_12 RULE_13 RULE_14
        status_nxt = (status_r & ~SR_WR_MASK) |
                     (hold_r & SR_WR_MASK); // RULE_09
        wel_nxt = hold_r[SR_WEL_BIT];
        stwr_nxt = 1'b1; // RULE_15
        if (byte_cnt_r == BYTES_TWO) begin
          config_nxt = (config_r & ~CR_WR_MASK) |
                       (shin_r & CR_WR_MASK); // RULE_10
          cfwr_nxt = 1'b1; // RULE_15
        end
      end
    end else if (cs_fall) begin
      state_nxt = ST_OPCODE;
      bit_cnt_nxt = CNT_ZERO;
      byte_cnt_nxt = BYTES_NONE;
    end else if (sck_rise) begin
      bit_cnt_nxt = bit_cnt_r + CNT_ONE;
      case (state_r)
        ST_OPCODE: begin
          shin_nxt = bit_in;
          if (bit_cnt_r == BIT_LAST_BYTE) begin
            bit_cnt_nxt = CNT_ZERO;
            state_nxt = decode(bit_in); // RULE_01
            fast_nxt = (bit_in != OP_READ); // RULE_18
            dual_nxt = (bit_in == OP_DUAL_RD);
          end
        end
        ST_WRITE_ENABLE_CMD_END: begin
          state_nxt = ST_IGNORE;
        end
        ST_ADDR: begin
          addr_nxt = {addr_r[ADDR_W-2:0], din}; // RULE_16
          if (bit_cnt_r == BIT_LAST_ADDR) begin
            bit_cnt_nxt = CNT_ZERO;
            state_nxt = fast_r ? ST_DUMMY : ST_RD_DATA;
          end
        end
        ST_DUMMY: begin
          // Data input not looked at and outputs stay released
          if (bit_cnt_r == BIT_LAST_BYTE) begin // RULE_19
            bit_cnt_nxt = CNT_ZERO;
            state_nxt = ST_RD_DATA; // RULE_18 RULE_20
          end
        end
        ST_VR_WDATA, ST_SR_DATA: begin
          shin_nxt = bit_in;
          if (bit_cnt_r == BIT_LAST_BYTE) begin
            bit_cnt_nxt = CNT_ZERO;
            if (byte_cnt_r == BYTES_NONE) begin
              hold_nxt = bit_in;
            end
            // Count saturates so a fifth or later byte still refuses the write
            if (byte_cnt_r != BYTES_MANY) begin
              byte_cnt_nxt = byte_cnt_r + BYTES_ONE; // RULE_13
            end
          end
        end
        default: begin
          bit_cnt_nxt = bit_cnt_r;
        end
      endcase
    end
    if (taken && (state_r == ST_RD_DATA) && !cs_rise) begin
      // Next byte is fetched while the current one is shifted out
      addr_nxt = (addr_r == ADDR_TOP) ? ADDR_ZERO :
                 addr_r + ADDR_ONE; // RULE_17
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= CNT_ZERO;
      byte_cnt_r <= BYTES_NONE;
      shin_r <= BYTE_ZERO;
      hold_r <= BYTE_ZERO;
      addr_r <= ADDR_ZERO;
      fast_r <= 1'b0;
      dual_r <= 1'b0;
      wel_r <= 1'b0;
      buffer_enable_bit_r <= 1'b0;
      status_r <= SR_RESET;
      config_r <= CR_RESET;
      stwr_r <= 1'b0;
      cfwr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      shin_r <= shin_nxt;
      hold_r <= hold_nxt;
      addr_r <= addr_nxt;
      fast_r <= fast_nxt;
      dual_r <= dual_nxt;
      wel_r <= wel_nxt;
      buffer_enable_bit_r <= buffer_enable_bit_nxt;
      status_r <= status_nxt;
      config_r <= config_nxt;
      stwr_r <= stwr_nxt;
      cfwr_r <= cfwr_nxt;
    end
  end

  // Dual mode puts the higher bit of each pair on line one
  assign IO1_O = bits[1]; // RULE_20
  assign IO1_OE_O = drive & run; // RULE_22
  assign IO0_O = bits[0];
  assign IO0_OE_O = drive & run & dual_r;
  assign MEM_ADDR_O = addr_r;
  assign WEL_O = wel_r;
  assign BUFFER_ENABLE_BIT_O = buffer_enable_bit_r;
  always_comb begin
    STATUS_O = status_r;
    STATUS_O[SR_WEL_BIT] = wel_r;
  end
  assign CONFIG_O = config_r;
  assign STATUS_WR_O = stwr_r;
  assign CONFIG_WR_O = cfwr_r;
endmodule

// ---- hdl/eecmd_pkg.sv ----
// Purpose: Shared constants and types of the serial command block
// Assumes: One 8-bit opcode per frame, address sent MSB first
// Notes: Register field positions are local choices
package eecmd_pkg;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_VREG_RD = 8'h85;
  localparam logic [7:0] OP_VREG_WR = 8'h81;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_RD = 8'h0b;
  localparam logic [7:0] OP_DUAL_RD = 8'h3b;
  localparam int ADDR_W = 24;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 24'hffffff;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 24'h000001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h000000;
  localparam logic [4:0] BIT_LAST_BYTE = 5'h07;
  localparam logic [4:0] BIT_LAST_ADDR = 5'h17;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;
  localparam logic [1:0] BYTES_MANY = 2'h3;
  // Status byte: write protect disable, top/bottom, protect field, latch
  localparam int SR_WEL_BIT = 1;
  localparam logic [7:0] SR_WR_MASK = 8'hbc;
  localparam logic [7:0] SR_RESET = 8'h00;
  // Configuration byte: id page lock and drive strength field
  localparam logic [7:0] CR_WR_MASK = 8'h83;
  localparam logic [7:0] CR_RESET = 8'h00;
  // Volatile byte: buffer enable and buffer loaded
  localparam int VR_BUFFER_ENABLE_BIT_BIT = 0;
  localparam int VR_BUFFER_LOADED_FLAG_BIT = 1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] TX_CNT_END = 3'h0;
  localparam logic [2:0] TX_STEP_1 = 3'h1;
  localparam logic [2:0] TX_STEP_2 = 3'h2;
  localparam int SYNC_N = 3;
  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_WRITE_ENABLE_CMD_END, ST_ADDR, ST_DUMMY, ST_RD_DATA,
    ST_VR_READ, ST_VR_WDATA, ST_SR_DATA, ST_IGNORE
  } eecmd_state_t;
endpackage

// ---- hdl/eecmd_sync.sv ----
// Purpose: Two-stage synchronisers and edge detection for the pins
// Assumes: Pins are asynchronous to CLK_I
// Notes: Edges come from stages two and three only
`timescale 1ns/1ps
module eecmd_sync (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [eecmd_pkg::SYNC_N-1:0] pin_i,
  output logic [eecmd_pkg::SYNC_N-1:0] lvl_o,
  output logic [eecmd_pkg::SYNC_N-1:0] rise_o,
  output logic [eecmd_pkg::SYNC_N-1:0] fall_o
);
  import eecmd_pkg::*;
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic s1_nxt;
      logic s2_nxt;
      logic s3_nxt;
      always_comb begin
        s1_nxt = pin_i[g];
        s2_nxt = s1_r;
        s3_nxt = s2_r;
      end
      // Reset high so that an idle chip select shows no false edge
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
        end else begin
          s1_r <= s1_nxt;
          s2_r <= s2_nxt;
          s3_r <= s3_nxt;
        end
      end
      assign lvl_o[g] = s2_r;
      assign rise_o[g] = s2_r & ~s3_r;
      assign fall_o[g] = ~s2_r & s3_r;
    end
  endgenerate
endmodule

// ---- hdl/eecmd_tx.sv ----
// Purpose: Output serialiser, one or two bits per falling serial edge
// Assumes: byte_i is stable for a few clocks before each byte start
// Notes: Drives nothing while run_i is low
`timescale 1ns/1ps
module eecmd_tx (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic dual_i,
  input wire logic fall_i,
  input wire logic [7:0] byte_i,
  output logic taken_o,
  output logic drive_o,
  output logic [1:0] bits_o
);
  import eecmd_pkg::*;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [1:0] out_r;
  logic [1:0] out_nxt;
  logic drv_r;
  logic drv_nxt;
  logic [7:0] src;
  logic [2:0] step;
  always_comb begin
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    drv_nxt = drv_r;
    taken_o = 1'b0;
    step = dual_i ? TX_STEP_2 : TX_STEP_1;
    src = (cnt_r == TX_CNT_END) ? byte_i : sh_r;
    if (!run_i) begin
      cnt_nxt = TX_CNT_END;
      drv_nxt = 1'b0;
    end else if (fall_i) begin
      // Byte taken at its first falling edge so next data can settle
      taken_o = (cnt_r == TX_CNT_END);
      drv_nxt = 1'b1;
      out_nxt = dual_i ? src[7:6] : {src[7], src[7]}; // RULE_20
      sh_nxt = dual_i ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
      cnt_nxt = cnt_r + step;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_r <= BYTE_ZERO;
      cnt_r <= TX_CNT_END;
      out_r <= 2'b00;
      drv_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
      drv_r <= drv_nxt;
    end
  end
  assign drive_o = drv_r;
  assign bits_o = out_r;
endmodule

// ---- tb/eecmd_checker.sv ----
// Purpose: Port checks for the serial command block
// Assumes: Select stays high four clocks or more between frames
// Notes: Bound into every instance of the block
`timescale 1ns/1ps
module eecmd_checker (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CS_N_I,
  input wire logic SCK_I,
  input wire logic IO0_OE_O,
  input wire logic IO1_OE_O,
  input wire logic WEL_O,
  input wire logic BUFFER_ENABLE_BIT_O,
  input wire logic [7:0] CONFIG_O,
  input wire logic STATUS_WR_O,
  input wire logic CONFIG_WR_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_oe_idle_off:
    assert property (CS_N_I [*6] |-> !IO1_OE_O && !IO0_OE_O)
    else $error("Output driven outside a frame");
  a_io0_dual_only:
    assert property (IO0_OE_O |-> IO1_OE_O)
    else $error("Line 0 driven without line 1");
  // Synchroniser delay puts the serial fall three clocks back
  a_oe_on_fall:
    assert property ($rose(IO1_OE_O) |->
      !$past(SCK_I, 3) && !$past(CS_N_I, 3))
    else $error("Output enabled away from a serial fall");
  a_cfg_with_stat:
    assert property (CONFIG_WR_O |-> STATUS_WR_O)
    else $error("Config commit without status commit");
  a_stat_needs_wel:
    assert property (STATUS_WR_O |-> $past(WEL_O))
    else $error("Status commit without write latch");
  a_cfg_ro_bits:
    assert property ((CONFIG_O & 8'h7c) == 8'h00)
    else $error("Config read-only bits set");
  a_cfg_on_commit:
    assert property ($changed(CONFIG_O) |-> CONFIG_WR_O || $past(CONFIG_WR_O))
    else $error("Config changed without commit");
  a_buffer_enable_bit_needs_wel:
    assert property ($changed(BUFFER_ENABLE_BIT_O) |-> $past(WEL_O))
    else $error("Buffer enable changed without latch");
  a_stat_one_pulse:
    assert property (STATUS_WR_O |=> !STATUS_WR_O)
    else $error("Status commit longer than one cycle");
  // Select rise reaches the commit strobe three clocks later
  a_commit_after_sel:
    assert property (STATUS_WR_O |-> CS_N_I && $past(CS_N_I, 3))
    else $error("Status commit without select rise");
endmodule

bind eecmd_core eecmd_checker chk_i (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .CS_N_I(CS_N_I), .SCK_I(SCK_I), .IO0_OE_O(IO0_OE_O), .IO1_OE_O(IO1_OE_O),
  .WEL_O(WEL_O), .BUFFER_ENABLE_BIT_O(BUFFER_ENABLE_BIT_O), .CONFIG_O(CONFIG_O),
  .STATUS_WR_O(STATUS_WR_O), .CONFIG_WR_O(CONFIG_WR_O));

// ---- tb/eecmd_host.sv ----
// Purpose: Serial host model driving select, clock and data in
// Assumes: Mode 0, clock idles low, 200 ns serial period
// Notes: Data line toggles when it carries no command bits
`timescale 1ns/1ps
module eecmd_host (
  input wire logic q0_i,
  input wire logic q1_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic d_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    d_o = 1'b0;
  end
  // Sends ntx bits MSB first, then nrx clocks of returned data
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx,
      input bit dual, output logic [23:0] rx);
    rx = 24'h0;
    cs_n_o = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      d_o = (i < ntx) ? tx[39 - i] : ~d_o;
      #100;
      // Taken just before the rise, where the device bit is settled
      if (i >= ntx) begin
        rx = dual ? {rx[21:0], q1_i, q0_i} : {rx[22:0], q1_i};
      end
      sck_o = 1'b1;
      #100;
      sck_o = 1'b0;
    end
    #100;
    cs_n_o = 1'b1;
    d_o = ~d_o;
    #200;
  endtask
endmodule

// ---- tb/test_eecmd_core.sv ----
// Purpose: Self-checking bench for the serial command block
// Assumes: Host model paces the serial clock at 200 ns
// Notes: Array bytes come from a fixed address hash
`timescale 1ns/1ps
module test_eecmd_core;
  import eecmd_pkg::*;
  logic CLK_I, RESETN_I, CS_N_I, SCK_I, IO0_I, IO0_O, IO0_OE_O, IO1_O;
  logic IO1_OE_O, WIP_I, BUFFER_LOADED_FLAG_I, WEL_O, BUFFER_ENABLE_BIT_O, STATUS_WR_O;
  logic CONFIG_WR_O, hd, q1;
  logic [7:0] MEM_DATA_I, STATUS_O, CONFIG_O, d1, d2, vb, s0, c0;
  logic [ADDR_W-1:0] MEM_ADDR_O, a;
  logic [23:0] rx;
  logic [7:0] ops[3] = '{OP_READ, OP_FAST_RD, OP_DUAL_RD};
  int nts[6] = '{16, 24, 24, 32, 24, 20};
  int bad_count = 0;
  int comparisons = 0;
  int nt;
  int stw_cnt = 0, cfw_cnt = 0, oe_cnt = 0, p0, p1;
  function automatic logic [7:0] mem_f(input logic [23:0] x);
    return x[7:0] ^ x[23:16] ^ 8'h3c;
  endfunction
  function automatic logic [23:0] exp3(input logic [23:0] x);
    return {mem_f(x), mem_f(x + 24'h1), mem_f(x + 24'h2)};
  endfunction
  // Undriven lines show a wrong value rather than a lucky one
  assign IO0_I = IO0_OE_O ? IO0_O : hd;
  assign q1 = IO1_OE_O ? IO1_O : ~IO1_O;
  assign MEM_DATA_I = mem_f(MEM_ADDR_O);
  // Counted on the falling edge, where the strobes are settled
  always @(negedge CLK_I) begin
    stw_cnt <= stw_cnt + int'(STATUS_WR_O);
    cfw_cnt <= cfw_cnt + int'(CONFIG_WR_O);
    oe_cnt <= oe_cnt + int'(IO1_OE_O | IO0_OE_O);
  end
  eecmd_core DUT (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CS_N_I(CS_N_I),
    .SCK_I(SCK_I), .IO0_I(IO0_I), .IO0_O(IO0_O), .IO0_OE_O(IO0_OE_O),
    .IO1_O(IO1_O), .IO1_OE_O(IO1_OE_O), .WIP_I(WIP_I), .BUFFER_LOADED_FLAG_I(BUFFER_LOADED_FLAG_I),
    .MEM_DATA_I(MEM_DATA_I), .MEM_ADDR_O(MEM_ADDR_O), .WEL_O(WEL_O),
    .BUFFER_ENABLE_BIT_O(BUFFER_ENABLE_BIT_O), .STATUS_O(STATUS_O), .CONFIG_O(CONFIG_O),
    .STATUS_WR_O(STATUS_WR_O), .CONFIG_WR_O(CONFIG_WR_O));
  eecmd_host host (.q0_i(IO0_I), .q1_i(q1), .cs_n_o(CS_N_I), .sck_o(SCK_I),
    .d_o(hd));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
      input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic xf(input logic [39:0] tx, input int n, input int nr,
      input bit dl);
    @(posedge CLK_I);
    #3;
    host.frame(tx, n, nr, dl, rx);
  endtask
  task automatic write_enable_cmd();
    xf({OP_WR_ENABLE, 32'h0}, 8, 0, 0);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end
  // 24 frames of at most about 13 us each fit well inside this span
  initial begin
    #1ms;
    bad_count++;
    results();
  end
  initial begin
    RESETN_I = 1'b0;
    WIP_I = 1'b0;
    BUFFER_LOADED_FLAG_I = 1'b0;
    void'($urandom(59));
    repeat (6) @(posedge CLK_I);
    #3;
    RESETN_I = 1'b1;
    repeat (8) @(posedge CLK_I);
    d1 = 8'($urandom()) | 8'h01;
    xf({OP_VREG_WR, d1, 24'h0}, 16, 0, 0);
    chk(24'(BUFFER_ENABLE_BIT_O), 24'h0, "write without latch");
    write_enable_cmd();
    chk(24'(WEL_O), 24'h1, "latch set");
    xf({OP_VREG_WR, d1, 24'h0}, 16, 0, 0);
    chk(24'(BUFFER_ENABLE_BIT_O), 24'h1, "buffer enable");
    xf({OP_VREG_WR, 8'h00, 24'h0}, 17, 0, 0);
    chk(24'(BUFFER_ENABLE_BIT_O), 24'h1, "misaligned write");
    WIP_I = 1'b1;
    BUFFER_LOADED_FLAG_I = 1'($urandom());
    vb = {6'h0, BUFFER_LOADED_FLAG_I, 1'b1};
    xf({OP_VREG_RD, 32'h0}, 8, 16, 0);
    chk(rx, {8'h0, vb, vb}, "volatile read");
    done("volatile");
    for (int k = 0; k < 6; k++) begin
      if (k != 1) begin
        write_enable_cmd();
      end else begin
        xf({OP_WR_ENABLE, 32'h0}, 9, 0, 0);
        chk(24'(WEL_O), 24'h0, "late write enable");
      end
      d1 = 8'($urandom()) & ((k == 0) ? 8'hfd : 8'hff);
      d2 = 8'($urandom());
      WIP_I = (k == 4);
      s0 = (k == 0 || k == 2) ? d1 & 8'hbe : STATUS_O;
      c0 = (k == 2) ? d2 & 8'h83 : CONFIG_O;
      p0 = stw_cnt;
      p1 = cfw_cnt;
      xf({OP_STAT_WR, d1, d2, 16'h0}, nts[k], 0, 0);
      chk(24'(STATUS_O), 24'(s0), "status");
      chk(24'(CONFIG_O), 24'(c0), "config");
      chk(24'(stw_cnt - p0), 24'(k == 0 || k == 2), "commit");
      chk(24'(cfw_cnt - p1), 24'(k == 2), "cfg commit");
    end
    WIP_I = 1'b0;
    done("status");
    // Half the reads start one byte below the top to force the wrap
    for (int k = 0; k < 6; k++) begin
      a = (k < 3) ? 24'hfffffe : 24'($urandom());
      d1 = 8'($urandom());
      nt = (ops[k % 3] == OP_READ) ? 32 : 40;
      xf({ops[k % 3], a, d1}, nt, (k % 3 == 2) ? 12 : 24,
        k % 3 == 2);
      chk(rx, exp3(a), "read");
    end
    done("reads");
    // Bit six is clear in every decoded opcode
    d1 = 8'($urandom()) | 8'h40;
    nt = oe_cnt;
    xf({d1, 32'($urandom())}, 32, 16, 0);
    chk(24'(oe_cnt - nt), 24'h0, "unknown op drive");
    chk(24'(WEL_O), 24'h1, "unknown op latch");
    done("unknown");
    results();
  end
endmodule
